// *** rtl/adc_dma_pkg.sv ***
/*
 * shared constants for the converter-to-RAM instruction sequencer:
 * special-function register offsets, control bit positions, reset values,
 * instruction word fields and instruction buffer geometry.
 * assumes a byte-wide register bus with one shared address space.
 */
package adc_dma_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR      = 8'hd8;
    localparam logic [7:0] DPTR_LO_ADDR   = 8'hdb;
    localparam logic [7:0] DPTR_HI_ADDR   = 8'hdc;
    localparam logic [7:0] IBUF_PTR_ADDR  = 8'hdd;
    localparam logic [7:0] IBUF_DATA_ADDR = 8'hde;
    localparam logic [7:0] LIMIT_LO_ADDR  = 8'hf9;
    localparam logic [7:0] LIMIT_HI_ADDR  = 8'hfa;
    localparam logic [7:0] COUNT_LO_ADDR  = 8'hfb;
    localparam logic [7:0] COUNT_HI_ADDR  = 8'hfc;
    localparam logic [7:0] BOUND_ADDR     = 8'hfd;
    localparam logic [7:0] ISW_ADDR       = 8'hfe;

    // ------------------------------------------------------------------
    // control register bits
    // ------------------------------------------------------------------
    localparam int EN_BIT      = 7;
    localparam int DONE_BIT    = 6;
    localparam int MODE_BIT    = 5;
    localparam int ERR_B_BIT   = 4;
    localparam int ERR_A_BIT   = 3;
    localparam int WARN_EN_BIT = 2;
    localparam int WARN_B_BIT  = 1;
    localparam int WARN_A_BIT  = 0;

    // ------------------------------------------------------------------
    // reset values, instruction fields and instruction buffer geometry
    // ------------------------------------------------------------------
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [7:0]  BYTE_RESET  = 8'h00;
    localparam logic [15:0] WORD_RESET  = 16'h0000;
    localparam int          INSTR_A_BIT = 4;
    localparam int          INSTR_B_BIT = 5;
    localparam int          INSTR_D_BIT = 6;
    localparam int          CONTINUOUS_CONVERSION_BIT_BIT    = 7;
    localparam int          IBUF_AW     = 6;
    localparam int          IBUF_DEPTH  = 64;

    typedef enum {S_IDLE, S_FETCH, S_DECODE, S_WAIT, S_WRITE} seq_state_type;

endpackage

// *** rtl/instr_buf_if.sv ***
/*
 * carrier between the sequencer and its instruction buffer.
 * assumes both ends run on the same clock.
 */
interface instr_buf_if;
    import adc_dma_pkg::*;
    logic               wr_en;
    logic [IBUF_AW-1:0] wr_addr;
    logic [7:0]         wr_data;
    logic [IBUF_AW-1:0] rd_addr;
    logic [7:0]         rd_data;
    modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
    modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// *** rtl/instr_buffer.sv ***
/*
 * instruction buffer: byte-wide memory, one write port, registered read.
 * assumes the reader waits one cycle after changing the read address.
 */
module instr_buffer
    import adc_dma_pkg::*;
(
    input  wire logic mclk_i,
    instr_buf_if.mem  bus
);
    logic [7:0] mem [IBUF_DEPTH];

    // ------------------------------------------------------------------
    // storage; no reset so it maps onto plain ram
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (bus.wr_en) begin
            mem[bus.wr_addr] <= bus.wr_data;
        end
        bus.rd_data <= mem[bus.rd_addr];
    end
endmodule

// *** rtl/adc_dma_sequencer.sv ***
/*
 * instruction sequencer moving two 16-bit converter results into data ram,
 * with its control/status and pointer registers on the byte register bus.
 * assumes converters and ram port share mclk_i; srst_i synchronous.
 */
// Contract
// - starting an operation cycle loads status pointer from boundary register.
// - fetch instruction at status pointer, then wait for requested converter data.
// - each finished instruction decrements repeat counter; repeat until it hits zero.
// - at zero reload counter from limit and step status pointer by one.
// - end-of-operation instruction restores status pointer to boundary value.
// - end instruction with continuous bit set keeps executing.
// - end instruction with continuous bit clear stops execution.
// - per-converter lost-data error flags, bits 4 and 3, software cleared.
// - decode end, continue, converter a, b, both, differential, differential plus b.
// - each data instruction writes two or four bytes to ram.
// - result arriving before earlier one is written is overflow; may drop. here it is buffered with a warn flag; only a third word is dropped.
// - sixteen-bit data pointer addresses every ram write.
module adc_dma_sequencer
    import adc_dma_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    input  wire logic        conv_a_valid_i,
    input  wire logic [15:0] conv_a_data_i,
    input  wire logic        conv_b_valid_i,
    input  wire logic [15:0] conv_b_data_i,
    input  wire logic        xram_ready_i,
    output logic             xram_wr_o,
    output logic      [15:0] xram_addr_o,
    output logic      [7:0]  xram_data_o,
    output logic             warn_irq_o
);
    instr_buf_if ibuf ();

    seq_state_type state, next_state;
    logic [7:0]  ctrl, next_ctrl, bound, next_bound, isw, next_isw;
    logic [7:0]  ibuf_ptr, next_ibuf_ptr, instr, next_instr;
    logic [15:0] limit, next_limit, count, next_count, dptr, next_dptr;
    logic [31:0] wbuf, next_wbuf;
    logic [2:0]  left, next_left;
    logic [1:0]  cnt [2], next_cnt [2];
    logic [15:0] w0 [2], next_w0 [2], w1 [2], next_w1 [2];
    logic [7:0]  next_rdata, next_xdata;
    logic [15:0] next_xaddr;
    logic        next_xwr, next_irq, ctrl_wr, byte_done;
    logic [1:0]  push, need, take;

    // need converter a for single or differential, b for its own bit
    function automatic logic [1:0] need_of(input logic [7:0] ins);
        return {ins[INSTR_B_BIT], ins[INSTR_A_BIT] | ins[INSTR_D_BIT]};
    endfunction

    instr_buffer u_ibuf (
        .mclk_i (mclk_i),
        .bus    (ibuf.mem)
    );

    // ------------------------------------------------------------------
    // register bus side of the instruction buffer
    // ------------------------------------------------------------------
    assign ibuf.wr_en   = sfr_wr_i && sfr_addr_i == IBUF_DATA_ADDR;
    assign ibuf.wr_addr = ibuf_ptr[IBUF_AW-1:0];
    assign ibuf.wr_data = sfr_wdata_i;
    assign ibuf.rd_addr = isw[IBUF_AW-1:0];
    assign ctrl_wr      = sfr_wr_i && sfr_addr_i == CTRL_ADDR;
    assign push         = {conv_b_valid_i, conv_a_valid_i};
    assign need         = need_of(instr);
    assign byte_done    = state == S_WRITE && xram_ready_i && left == 3'd1;

    // ------------------------------------------------------------------
    // next-state logic for sequencer, buffers and registers
    // ------------------------------------------------------------------
    always_comb begin
        logic [15:0] dec;
        dec           = 16'(count - 16'h0001);
        next_state    = state;
        next_ctrl     = ctrl;
        next_bound    = bound;
        next_isw      = isw;
        next_ibuf_ptr = ibuf_ptr;
        next_instr    = instr;
        next_limit    = limit;
        next_count    = count;
        next_dptr     = dptr;
        next_wbuf     = wbuf;
        next_left     = left;
        next_xwr      = 1'b0;
        next_xaddr    = xram_addr_o;
        next_xdata    = xram_data_o;
        take          = 2'b00;
        // software writes; flags clear on zero, ones leave them alone
        if (ctrl_wr) begin
            next_ctrl[MODE_BIT]    = sfr_wdata_i[MODE_BIT];
            next_ctrl[WARN_EN_BIT] = sfr_wdata_i[WARN_EN_BIT];
            next_ctrl[DONE_BIT]    = ctrl[DONE_BIT] & sfr_wdata_i[DONE_BIT];
            next_ctrl[ERR_B_BIT]   = ctrl[ERR_B_BIT] & sfr_wdata_i[ERR_B_BIT];
            next_ctrl[ERR_A_BIT]   = ctrl[ERR_A_BIT] & sfr_wdata_i[ERR_A_BIT];
            next_ctrl[WARN_B_BIT]  = ctrl[WARN_B_BIT] & sfr_wdata_i[WARN_B_BIT];
            next_ctrl[WARN_A_BIT]  = ctrl[WARN_A_BIT] & sfr_wdata_i[WARN_A_BIT];
        end
        if (sfr_wr_i) begin
            case (sfr_addr_i)
                DPTR_LO_ADDR:   next_dptr[7:0]   = sfr_wdata_i;
                DPTR_HI_ADDR:   next_dptr[15:8]  = sfr_wdata_i;
                IBUF_PTR_ADDR:  next_ibuf_ptr    = sfr_wdata_i;
                IBUF_DATA_ADDR: next_ibuf_ptr    = ibuf_ptr + 8'h01;
                LIMIT_LO_ADDR:  next_limit[7:0]  = sfr_wdata_i;
                LIMIT_HI_ADDR:  next_limit[15:8] = sfr_wdata_i;
                COUNT_LO_ADDR:  next_count[7:0]  = sfr_wdata_i;
                COUNT_HI_ADDR:  next_count[15:8] = sfr_wdata_i;
                BOUND_ADDR:     next_bound       = sfr_wdata_i;
                default: ;
            endcase
        end
        // sequencer; a stop request overrides whatever it was doing
        case (state)
            S_IDLE: begin
                if (ctrl_wr && sfr_wdata_i[EN_BIT] && sfr_wdata_i[MODE_BIT])
                begin
                    next_isw   = bound;
                    next_state = S_FETCH;
                end
            end
            S_FETCH: next_state = S_DECODE;
            S_DECODE: begin
                if (ibuf.rd_data[6:0] == 7'h00) begin
                    next_isw = bound;
                    if (ibuf.rd_data[CONTINUOUS_CONVERSION_BIT_BIT]) begin
                        next_state = S_FETCH;
                    end else begin
                        next_state         = S_IDLE;
                        next_ctrl[DONE_BIT] = 1'b1;
                    end
                end else begin
                    next_instr = ibuf.rd_data;
                    next_state = S_WAIT;
                end
            end
            S_WAIT: begin
                // wait until every requested word is buffered
                if ((!need[0] || cnt[0] != 2'd0) &&
                    (!need[1] || cnt[1] != 2'd0)) begin
                    take       = need;
                    next_state = S_WRITE;
                    // a-side word goes first, two or four bytes in all
                    if (need == 2'b11) begin
                        next_wbuf = {w0[0], w0[1]};
                        next_left = 3'd4;
                    end else begin
                        next_wbuf = {need[0] ? w0[0] : w0[1], 16'h0000};
                        next_left = 3'd2;
                    end
                end
            end
            S_WRITE: begin
                // ram port may stall; bytes leave high byte first
                if (xram_ready_i) begin
                    next_xwr   = 1'b1;
                    next_xaddr = dptr;
                    next_xdata = wbuf[31:24];
                    next_dptr  = dptr + 16'h0001;
                    next_wbuf  = {wbuf[23:0], 8'h00};
                    next_left  = left - 3'd1;
                    if (left == 3'd1) begin
                        next_state = S_FETCH;
                        if (dec == WORD_RESET) begin
                            next_count = limit;
                            next_isw   = isw + 8'h01;
                        end else begin
                            next_count = dec;
                        end
                    end
                end
            end
            default: next_state = S_IDLE;
        endcase
        if (ctrl_wr && !sfr_wdata_i[EN_BIT]) begin
            next_state = S_IDLE;
        end
        next_ctrl[EN_BIT] = next_state != S_IDLE;
        // two-word buffer per converter; a third word is lost
        for (int c = 0; c < 2; c++) begin
            next_cnt[c] = cnt[c];
            next_w0[c]  = w0[c];
            next_w1[c]  = w1[c];
            if (take[c]) begin
                next_w0[c]  = w1[c];
                next_cnt[c] = cnt[c] - 2'd1;
            end
            if (push[c] && state != S_IDLE) begin
                if (next_cnt[c] == 2'd2) begin
                    next_ctrl[c == 0 ? ERR_A_BIT : ERR_B_BIT] = 1'b1;
                end else begin
                    if (next_cnt[c] == 2'd0) begin
                        next_w0[c] = c == 0 ? conv_a_data_i : conv_b_data_i;
                    end else begin
                        next_w1[c] = c == 0 ? conv_a_data_i : conv_b_data_i;
                        next_ctrl[c == 0 ? WARN_A_BIT : WARN_B_BIT] = 1'b1;
                    end
                    next_cnt[c] = next_cnt[c] + 2'd1;
                end
            end
            if (state == S_IDLE) begin
                next_cnt[c] = 2'd0;
            end
        end
        next_irq = next_ctrl[WARN_EN_BIT] &
                   (next_ctrl[WARN_A_BIT] | next_ctrl[WARN_B_BIT]);
        // read data; unmapped offsets answer zero
        case (sfr_addr_i)
            CTRL_ADDR:     next_rdata = ctrl;
            DPTR_LO_ADDR:  next_rdata = dptr[7:0];
            DPTR_HI_ADDR:  next_rdata = dptr[15:8];
            IBUF_PTR_ADDR: next_rdata = ibuf_ptr;
            LIMIT_LO_ADDR: next_rdata = limit[7:0];
            LIMIT_HI_ADDR: next_rdata = limit[15:8];
            COUNT_LO_ADDR: next_rdata = count[7:0];
            COUNT_HI_ADDR: next_rdata = count[15:8];
            BOUND_ADDR:    next_rdata = bound;
            ISW_ADDR:      next_rdata = isw;
            default:       next_rdata = BYTE_RESET;
        endcase
        if (!sfr_rd_i) begin
            next_rdata = sfr_rdata_o;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state       <= S_IDLE;
            ctrl        <= CTRL_RESET;
            bound       <= BYTE_RESET;
            isw         <= BYTE_RESET;
            ibuf_ptr    <= BYTE_RESET;
            instr       <= BYTE_RESET;
            limit       <= WORD_RESET;
            count       <= WORD_RESET;
            dptr        <= WORD_RESET;
            wbuf        <= '0;
            left        <= 3'd0;
            cnt         <= '{2'd0, 2'd0};
            w0          <= '{WORD_RESET, WORD_RESET};
            w1          <= '{WORD_RESET, WORD_RESET};
            sfr_rdata_o <= BYTE_RESET;
            xram_wr_o   <= 1'b0;
            xram_addr_o <= WORD_RESET;
            xram_data_o <= BYTE_RESET;
            warn_irq_o  <= 1'b0;
        end else begin
            state       <= next_state;
            ctrl        <= next_ctrl;
            bound       <= next_bound;
            isw         <= next_isw;
            ibuf_ptr    <= next_ibuf_ptr;
            instr       <= next_instr;
            limit       <= next_limit;
            count       <= next_count;
            dptr        <= next_dptr;
            wbuf        <= next_wbuf;
            left        <= next_left;
            cnt         <= next_cnt;
            w0          <= next_w0;
            w1          <= next_w1;
            sfr_rdata_o <= next_rdata;
            xram_wr_o   <= next_xwr;
            xram_addr_o <= next_xaddr;
            xram_data_o <= next_xdata;
            warn_irq_o  <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    sequence s_end_seen;
        state == S_DECODE && ibuf.rd_data[6:0] == 7'h00 && !ctrl_wr;
    endsequence
    property p_start;
        state == S_IDLE && ctrl_wr && sfr_wdata_i[EN_BIT] &&
        sfr_wdata_i[MODE_BIT] |=> state == S_FETCH && isw == $past(bound);
    endproperty
    a_start: assert property (p_start) else $error("start bad");
    property p_fetch;
        state == S_FETCH && !ctrl_wr |=> state == S_DECODE;
    endproperty
    a_fetch: assert property (p_fetch) else $error("no decode");
    property p_repeat;
        byte_done && count != 16'h0001 |=>
            count == $past(count) - 16'h0001 && isw == $past(isw);
    endproperty
    a_repeat: assert property (p_repeat) else $error("bad repeat");
    property p_reload;
        byte_done && count == 16'h0001 && !sfr_wr_i |=>
            count == $past(limit) && isw == $past(isw) + 8'h01;
    endproperty
    a_reload: assert property (p_reload) else $error("no reload");
    property p_restore;
        s_end_seen |=> isw == $past(bound);
    endproperty
    a_restore: assert property (p_restore) else $error("no restore");
    // a stop written during the refetch cycle legally ends the loop
    property p_continue;
        s_end_seen ##0 ibuf.rd_data[CONTINUOUS_CONVERSION_BIT_BIT] |=> state == S_FETCH ##1
            (state == S_DECODE || $past(ctrl_wr));
    endproperty
    a_continue: assert property (p_continue) else $error("stopped");
    property p_stop;
        s_end_seen ##0 !ibuf.rd_data[CONTINUOUS_CONVERSION_BIT_BIT] |=>
            state == S_IDLE && ctrl[DONE_BIT] && !ctrl[EN_BIT];
    endproperty
    a_stop: assert property (p_stop) else $error("no stop");
    property p_done_sticky;
        ctrl[DONE_BIT] && !ctrl_wr |=> ctrl[DONE_BIT];
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("lost");
    property p_overflow;
        state != S_IDLE && cnt[0] == 2'd2 && push[0] && !take[0] |=>
            ctrl[ERR_A_BIT] && cnt[0] == 2'd2;
    endproperty
    a_overflow: assert property (p_overflow) else $error("no error");
    property p_lost_b;
        state != S_IDLE && cnt[1] == 2'd2 && push[1] && !take[1] |=>
            ctrl[ERR_B_BIT] && cnt[1] == 2'd2;
    endproperty
    a_lost_b: assert property (p_lost_b) else $error("b lost");
    property p_irq;
        warn_irq_o |-> ctrl[WARN_EN_BIT];
    endproperty
    a_irq: assert property (p_irq) else $error("irq unmasked");
    property p_addr_step;
        xram_wr_o ##1 xram_wr_o |-> xram_addr_o == $past(xram_addr_o) + 16'h0001;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("addr skip");
endmodule

// *** testbench/adc_far_side.sv ***
/*
 * far-side model: two converters and a byte-wide data ram.
 * assumes the bench calls push_a/push_b and drives stall_i.
 */
module adc_far_side (
    input  wire logic        mclk_i,
    input  wire logic        stall_i,
    output logic             conv_a_valid_o,
    output logic      [15:0] conv_a_data_o,
    output logic             conv_b_valid_o,
    output logic      [15:0] conv_b_data_o,
    output logic             xram_ready_o,
    input  wire logic        xram_wr_i,
    input  wire logic [15:0] xram_addr_i,
    input  wire logic [7:0]  xram_data_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ram [logic [15:0]];
    int         wr_count = 0;
    initial begin
        conv_a_valid_o = 1'b0;
        conv_b_valid_o = 1'b0;
        conv_a_data_o = 16'h0000;
        conv_b_data_o = 16'h0000;
    end
    // result pulse; data line shows the inverse once released
    task automatic push_a(input logic [15:0] d);
        @(posedge mclk_i);
        #1 conv_a_valid_o = 1'b1;
        conv_a_data_o = d;
        @(posedge mclk_i);
        #1 conv_a_valid_o = 1'b0;
        conv_a_data_o = ~d;
    endtask
    task automatic push_b(input logic [15:0] d);
        @(posedge mclk_i);
        #1 conv_b_valid_o = 1'b1;
        conv_b_data_o = d;
        @(posedge mclk_i);
        #1 conv_b_valid_o = 1'b0;
        conv_b_data_o = ~d;
    endtask
    // a stalled ram lets the converters outrun the writes
    assign xram_ready_o = ~stall_i;
    always @(posedge mclk_i) begin
        if (xram_wr_i === 1'b1) begin
            ram[xram_addr_i] = xram_data_i;
            wr_count++;
        end
    end
endmodule

// *** testbench/adc_dma_instruction_sequencer_bench.sv ***
/*
 * self-checking bench for the converter-to-ram sequencer.
 * assumes the far-side model and the design package are compiled first.
 */
module adc_dma_instruction_sequencer_bench;
    import adc_dma_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i, srst_i, stall;
    logic sfr_wr_i, sfr_rd_i, a_v, b_v, rdy, xw, irq;
    logic [7:0]  sfr_addr_i, sfr_wdata_i, rdat, xd;
    logic [15:0] a_d, b_d, xa;
    int err_count = 0, comparisons = 0;
    always #4 mclk_i = ~mclk_i;
    adc_dma_sequencer i_adc_dma_sequencer (.mclk_i(mclk_i),
        .srst_i(srst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(rdat),
        .conv_a_valid_i(a_v), .conv_a_data_i(a_d), .conv_b_valid_i(b_v),
        .conv_b_data_i(b_d), .xram_ready_i(rdy), .xram_wr_o(xw),
        .xram_addr_o(xa), .xram_data_o(xd), .warn_irq_o(irq));
    adc_far_side i_adc_far_side (.mclk_i(mclk_i), .stall_i(stall),
        .conv_a_valid_o(a_v), .conv_a_data_o(a_d), .conv_b_valid_o(b_v),
        .conv_b_data_o(b_d), .xram_ready_o(rdy), .xram_wr_i(xw),
        .xram_addr_i(xa), .xram_data_i(xd));
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        #1 sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(posedge mclk_i);
        #1 sfr_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        #1 sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        @(posedge mclk_i);
        #1 sfr_rd_i = 1'b0;
        d = rdat;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk({8'h00, d}, {8'h00, e});
    endtask
    // bounded wait for a byte total at the ram
    task automatic wait_ram(input int n);
        int i;
        for (i = 0; i < 300 && i_adc_far_side.wr_count < n; i++) begin
            @(posedge mclk_i);
        end
        chk(16'(i_adc_far_side.wr_count), 16'(n));
        if (i_adc_far_side.wr_count < n) stop_test();
    endtask
    task automatic ram_word(input logic [15:0] a, input logic [15:0] e);
        chk({i_adc_far_side.ram[a], i_adc_far_side.ram[a + 16'h0001]}, e);
    endtask
    // two-word program at boundary 0x02, count, limit, data pointer
    task automatic load(input logic [7:0] i0, input logic [7:0] i1,
                        input logic [7:0] cnt, input logic [15:0] dp);
        wr(BOUND_ADDR, 8'h02);
        wr(IBUF_PTR_ADDR, 8'h02);
        wr(IBUF_DATA_ADDR, i0);
        wr(IBUF_DATA_ADDR, i1);
        wr(COUNT_LO_ADDR, cnt);
        wr(COUNT_HI_ADDR, 8'h00);
        wr(LIMIT_LO_ADDR, 8'h01);
        wr(LIMIT_HI_ADDR, 8'h00);
        wr(DPTR_LO_ADDR, dp[7:0]);
        wr(DPTR_HI_ADDR, dp[15:8]);
    endtask
    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    // both converters, two passes, then a stopping end word
    task automatic run_once();
        rchk(CTRL_ADDR, CTRL_RESET);
        rchk(8'h00, 8'h00);
        wr(CTRL_ADDR, 8'h80);
        rchk(CTRL_ADDR, 8'h00);
        load(8'h30, 8'h00, 8'h02, 16'h1234);
        wr(CTRL_ADDR, 8'ha0);
        i_adc_far_side.push_a(16'ha1b2);
        i_adc_far_side.push_b(16'hc3d4);
        wait_ram(4);
        i_adc_far_side.push_a(16'h1122);
        i_adc_far_side.push_b(16'h3344);
        wait_ram(8);
        ram_word(16'h1234, 16'ha1b2);
        ram_word(16'h1236, 16'hc3d4);
        ram_word(16'h1238, 16'h1122);
        ram_word(16'h123a, 16'h3344);
        repeat (10) @(posedge mclk_i);
        rchk(CTRL_ADDR, 8'h60);
        rchk(ISW_ADDR, 8'h02);
        rchk(COUNT_LO_ADDR, 8'h01);
        chk(16'(i_adc_far_side.wr_count), 16'd8);
        wr(CTRL_ADDR, 8'h60);
        rchk(CTRL_ADDR, 8'h60);
        wr(CTRL_ADDR, 8'h20);
        rchk(CTRL_ADDR, 8'h20);
    endtask
    // differential word with a continuing end word
    task automatic run_loop();
        load(8'h50, 8'h80, 8'h01, 16'h0100);
        wr(CTRL_ADDR, 8'ha0);
        i_adc_far_side.push_a(16'h5a5a);
        wait_ram(10);
        repeat (10) @(posedge mclk_i);
        rchk(CTRL_ADDR, 8'ha0);
        i_adc_far_side.push_a(16'h6b6b);
        wait_ram(12);
        ram_word(16'h0100, 16'h5a5a);
        ram_word(16'h0102, 16'h6b6b);
        wr(CTRL_ADDR, 8'h20);
        rchk(CTRL_ADDR, 8'h20);
    endtask
    // stalled ram: second word warns, third buffered word is lost
    task automatic run_overflow();
        load(8'h20, 8'h00, 8'h01, 16'h0200);
        stall = 1'b1;
        wr(CTRL_ADDR, 8'ha4);
        i_adc_far_side.push_b(16'h0001);
        repeat (6) @(posedge mclk_i);
        i_adc_far_side.push_b(16'h0002);
        i_adc_far_side.push_b(16'h0003);
        i_adc_far_side.push_b(16'h0004);
        // a-side words are never taken by this program, so a third is lost
        i_adc_far_side.push_a(16'h0011);
        i_adc_far_side.push_a(16'h0012);
        i_adc_far_side.push_a(16'h0013);
        repeat (2) @(posedge mclk_i);
        rchk(CTRL_ADDR, 8'hbf);
        chk({15'h0000, irq}, 16'h0001);
        wr(CTRL_ADDR, 8'ha4);
        rchk(CTRL_ADDR, 8'ha4);
        chk({15'h0000, irq}, 16'h0000);
        wr(CTRL_ADDR, 8'h00);
        stall = 1'b0;
    endtask
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        mclk_i      = 1'b0;
        srst_i      = 1'b1;
        stall       = 1'b0;
        sfr_wr_i    = 1'b0;
        sfr_rd_i    = 1'b0;
        sfr_addr_i  = 8'h00;
        sfr_wdata_i = 8'h00;
        repeat (12) @(posedge mclk_i);
        #1 srst_i = 1'b0;
        run_once();
        run_loop();
        run_overflow();
        stop_test();
    end
endmodule
